/* design/prsd_defs.svh */
// offsets, field positions, reset values and timing counts of the sequencer
// assumes: included by the package only; design files use its macros without including it
`ifndef PRSD_DEFS_SVH
`define PRSD_DEFS_SVH

// ************************************************************
// register byte offsets on apb
// ************************************************************
`define PRSD_OFF_BCT      12'h000
`define PRSD_OFF_PWAIT    12'h004
`define PRSD_OFF_PROM     12'h008
`define PRSD_OFF_DBCFG    12'h00c
`define PRSD_OFF_SDCFG    12'h010
`define PRSD_OFF_STATUS   12'h014
`define PRSD_OFF_RDATA    12'h018

// ************************************************************
// field positions
// ************************************************************
`define PRSD_BCT_CT7      0
`define PRSD_PWAIT_WS7_LO 0
`define PRSD_PWAIT_WS7_HI 2
`define PRSD_PROM_PWS_LO  0
`define PRSD_PROM_PWS_HI  2
`define PRSD_PROM_PS      4
`define PRSD_DBC_BW0      0
`define PRSD_SDC_TRP      0
`define PRSD_SDC_ACTIVATE_DELAY_BIT     1

// ************************************************************
// reset values and fixed figures
// ************************************************************
`define PRSD_RST_BCT      32'h0000_0000
`define PRSD_RST_PWAIT    32'h0000_0000
`define PRSD_RST_PROM     32'h0000_0000
`define PRSD_RST_DBC      32'h0000_0000
`define PRSD_RST_SDC      32'h0000_0000
`define PRSD_ROM_BLOCK    3'h7
`define PRSD_CAS_LAT      3'h2
`define PRSD_BANKS        4
`define PRSD_ROW_W        12

`endif

/* design/prsd_pkg.sv */
// types of the page-rom / sdram bus cycle sequencer
// assumes: prsd_defs.svh is on the include path
package prsd_pkg;
`include "prsd_defs.svh"

   // ************************************************************
   // request source and sdram command
   // ************************************************************
   typedef enum logic [2:0] {
      prsd_src_load, prsd_src_fetch, prsd_src_dma, prsd_src_store,
      prsd_src_icache, prsd_src_dcache, prsd_src_blkld, prsd_src_blkst
   } prsd_src_t;

   typedef enum logic [2:0] {
      prsd_cmd_nop, prsd_cmd_pre, prsd_cmd_act, prsd_cmd_rd, prsd_cmd_wr
   } prsd_sdcmd_t;

   // request from the core side
   typedef struct packed {
      logic        valid;
      prsd_src_t   src;
      logic        sdram;
      logic [2:0]  block;
      logic [1:0]  bank;
      logic [11:0] row;
      logic [7:0]  col;
      logic [1:0]  size;
   } prsd_req_t;

   // memory side outputs
   typedef struct packed {
      logic        rom_cs;
      logic        rom_strobe;
      logic        rom_addr_st;
      logic        off_page;
      logic        wide16;
      logic [3:0]  beat;
      prsd_sdcmd_t sd_cmd;
      logic [1:0]  sd_bank;
      logic [11:0] sd_addr;
      logic        sd_capture;
   } prsd_mem_t;
endpackage

/* design/prsd_row_table.sv */
// open-row table: one row register and valid flag per sdram bank
// assumes: lookup data registered, one cycle after the bank is presented
`timescale 1ns/10ps
module prsd_row_table (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // lookup
   input  wire logic [1:0]  bank,
   input  wire logic [11:0] row,
   output logic             hit,
   // update
   input  wire logic        open,
   input  wire logic        refresh
);
   import prsd_pkg::*;

   typedef struct packed {
      logic [`PRSD_BANKS-1:0]       vld;
      logic [`PRSD_BANKS-1:0][11:0] rows;
      logic                         hit;
   } prsd_rst_t;

   prsd_rst_t st, next_st;

   // per bank update; refresh clears every valid flag
   always_comb begin
      next_st = st;
      next_st.hit = st.vld[bank] && (st.rows[bank] == row);
      for (int i = 0; i < `PRSD_BANKS; i++) begin
         if (refresh) begin
            next_st.vld[i] = 1'b0;
         end else if (open && bank == i[1:0]) begin
            next_st.vld[i]  = 1'b1;
            next_st.rows[i] = row;
         end
      end
   end

   assign hit = st.hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

/* design/prsd_seq.sv */
// bus cycle sequencer for page-mode rom (block 7) and sdram
// assumes: apb from a single master, core request held until done pulses
`timescale 1ns/10ps
module prsd_seq (
   // apb clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   // core request
   input  wire prsd_pkg::prsd_req_t req,
   output logic                 req_done,
   output logic                 req_err,
   // strap and refresh
   input  wire logic            bus_width_strap_pin,
   input  wire logic            auto_refresh,
   // memory side
   input  wire logic            ready_n,
   output prsd_pkg::prsd_mem_t  mem
);
   import prsd_pkg::*;

   typedef enum logic [3:0] {
      s_idle, s_rom_addr, s_rom_strobe, s_sd_look, s_sd_pre, s_sd_act,
      s_sd_cmd, s_sd_drain, s_gap
   } prsd_state_t;

   typedef struct packed {
      prsd_state_t state;
      logic [31:0] bct, pwait, prom, dbc, sdram_config_register;
      logic [31:0] prdata;
      logic        pready, pslverr;
      logic        done, err;
      logic        burst, write, rd_core;
      logic [3:0]  beat, beats;
      logic [1:0]  gap;
      logic [2:0]  lat;
      logic [7:0]  reads;
      prsd_mem_t   mem;
   } prsd_st_t;

   prsd_st_t st, next_st;
   logic     wc_load, wc_step, wc_done, rt_hit, rt_open;
   logic [2:0] wc_waits;
   logic     is_burst, is_write, rom_sel, off_pg;

   // ************************************************************
   // helpers
   // ************************************************************
   prsd_wait_ctr u_wait (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (wc_load),
      .waits   (wc_waits),
      .step    (wc_step),
      .ready_n (ready_n),
      .done    (wc_done)
   );

   prsd_row_table u_rows (
      .pclk    (pclk),
      .presetn (presetn),
      .bank    (req.bank),
      .row     (req.row),
      .hit     (rt_hit),
      .open    (rt_open),
      .refresh (auto_refresh)
   );

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb begin
      next_st   = st;
      wc_load   = 1'b0;
      wc_step   = 1'b0;
      wc_waits  = st.pwait[`PRSD_PWAIT_WS7_HI:`PRSD_PWAIT_WS7_LO];
      rt_open   = 1'b0;
      is_burst  = req.src inside {prsd_src_icache, prsd_src_dcache, prsd_src_blkld, prsd_src_blkst};
      is_write  = req.src inside {prsd_src_store, prsd_src_blkst};
      rom_sel   = !req.sdram && req.block == `PRSD_ROM_BLOCK && st.bct[`PRSD_BCT_CT7];
      // rom off-page: first beat, or beat five on an 8-byte page in 16-bit mode
      off_pg    = (st.beat == 4'h0)
                  || (st.mem.wide16 && st.prom[`PRSD_PROM_PS] && st.beat == 4'h4);
      next_st.done = 1'b0;
      next_st.err  = 1'b0;
      next_st.mem.sd_cmd     = prsd_cmd_nop;
      next_st.mem.sd_capture = 1'b0;
      next_st.mem.rom_addr_st = 1'b0;
      // read capture pipeline, two clocks after each read command
      next_st.reads = {st.reads[6:0], st.mem.sd_cmd == prsd_cmd_rd};
      // the shift stage itself is one clock, so the tap sits one stage early
      if (st.reads[`PRSD_CAS_LAT-3'h2]) begin
         next_st.mem.sd_capture = 1'b1;
      end
      unique case (st.state)
         s_idle: begin
            if (req.valid && !st.done && !st.err) begin
               next_st.burst = is_burst;
               next_st.write = is_write;
               next_st.rd_core = !is_write;
               next_st.beat  = 4'h0;
               if (req.sdram) begin
                  next_st.mem.wide16 = st.dbc[`PRSD_DBC_BW0];
                  next_st.beats = is_burst ? 4'h4 : 4'h1;
                  next_st.mem.sd_bank = req.bank;
                  next_st.state = s_sd_look;
               end else if (rom_sel && !is_write && req.src != prsd_src_dcache) begin
                  next_st.mem.wide16 = bus_width_strap_pin;
                  next_st.beats = !is_burst ? 4'h1 : (bus_width_strap_pin ? 4'h8 : 4'h4);
                  next_st.state = s_rom_addr;
               end else begin
                  next_st.err = 1'b1;
               end
            end
         end
         s_rom_addr: begin
            next_st.mem.rom_cs      = 1'b1;
            next_st.mem.rom_addr_st = 1'b1;
            next_st.mem.off_page    = off_pg;
            next_st.mem.beat        = st.beat;
            wc_load  = 1'b1;
            wc_waits = off_pg ? st.pwait[`PRSD_PWAIT_WS7_HI:`PRSD_PWAIT_WS7_LO]
                              : st.prom[`PRSD_PROM_PWS_HI:`PRSD_PROM_PWS_LO];
            next_st.state = s_rom_strobe;
            next_st.mem.rom_strobe = 1'b1;
         end
         s_rom_strobe: begin
            wc_step = 1'b1;
            if (wc_done) begin
               if (st.beat + 4'h1 == st.beats) begin
                  next_st.mem.rom_cs     = 1'b0;
                  next_st.mem.rom_strobe = 1'b0;
                  next_st.done  = 1'b1;
                  next_st.gap   = 2'h1;
                  next_st.state = s_gap;
               end else begin
                  next_st.beat  = st.beat + 4'h1;
                  next_st.mem.rom_strobe = 1'b0;
                  next_st.state = s_rom_addr;
               end
            end
         end
         s_sd_look: begin
            // ready plays no part in any sdram state
            next_st.mem.sd_addr = {4'h0, req.col};
            if (rt_hit) begin
               next_st.mem.off_page = 1'b0;
               next_st.state = s_sd_cmd;
            end else begin
               next_st.mem.off_page = 1'b1;
               next_st.mem.sd_cmd = prsd_cmd_pre;
               next_st.gap   = st.sdram_config_register[`PRSD_SDC_TRP] ? 2'h1 : 2'h0;
               next_st.state = s_sd_pre;
            end
         end
         s_sd_pre: begin
            if (st.gap != 2'h0) begin
               next_st.gap = st.gap - 2'h1;
            end else begin
               next_st.mem.sd_cmd  = prsd_cmd_act;
               next_st.mem.sd_addr = req.row;
               rt_open = 1'b1;
               // short gap goes straight to the access, long gap waits one state
               next_st.gap   = 2'h0;
               next_st.state = st.sdram_config_register[`PRSD_SDC_ACTIVATE_DELAY_BIT] ? s_sd_act : s_sd_cmd;
            end
         end
         s_sd_act: begin
            if (st.gap != 2'h0) begin
               next_st.gap = st.gap - 2'h1;
            end else begin
               next_st.state = s_sd_cmd;
            end
         end
         s_sd_cmd: begin
            next_st.mem.sd_cmd  = st.write ? prsd_cmd_wr : prsd_cmd_rd;
            next_st.mem.sd_addr = {4'h0, req.col + {4'h0, st.beat[1:0], 2'h0}};
            next_st.mem.beat    = st.beat;
            if (st.beat + 4'h1 == st.beats) begin
               next_st.gap   = 2'(`PRSD_CAS_LAT);
               next_st.state = st.write ? s_gap : s_sd_drain;
               if (st.write) begin
                  next_st.done = 1'b1;
                  next_st.gap  = 2'h0;
               end
            end else begin
               next_st.beat = st.beat + 4'h1;
            end
         end
         s_sd_drain: begin
            if (st.gap != 2'h0) begin
               next_st.gap = st.gap - 2'h1;
            end else begin
               next_st.done  = 1'b1;
               next_st.gap   = st.rd_core ? 2'h1 : 2'h0;
               next_st.state = s_gap;
            end
         end
         s_gap: begin
            if (st.gap != 2'h0) begin
               next_st.gap = st.gap - 2'h1;
            end else begin
               next_st.state = s_idle;
            end
         end
      endcase

      // ************************************************************
      // apb slave, zero wait states
      // ************************************************************
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (psel && !penable) begin
         next_st.pready = 1'b1;
         if (pwrite) begin
            unique case (paddr)
               `PRSD_OFF_BCT:   next_st.bct   = pwdata;
               `PRSD_OFF_PWAIT: next_st.pwait = pwdata;
               `PRSD_OFF_PROM:  next_st.prom  = pwdata;
               `PRSD_OFF_DBCFG: next_st.dbc   = pwdata;
               `PRSD_OFF_SDCFG: next_st.sdram_config_register   = pwdata;
               default:         next_st.pslverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               `PRSD_OFF_BCT:    next_st.prdata = st.bct;
               `PRSD_OFF_PWAIT:  next_st.prdata = st.pwait;
               `PRSD_OFF_PROM:   next_st.prdata = st.prom;
               `PRSD_OFF_DBCFG:  next_st.prdata = st.dbc;
               `PRSD_OFF_SDCFG:  next_st.prdata = st.sdram_config_register;
               `PRSD_OFF_STATUS: next_st.prdata = {27'h0, st.mem.off_page, st.state};
               default: begin
                  next_st.prdata  = 32'h0;
                  next_st.pslverr = 1'b1;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st       <= '0;
         st.state <= s_idle;
         st.bct   <= `PRSD_RST_BCT;
         st.pwait <= `PRSD_RST_PWAIT;
         st.prom  <= `PRSD_RST_PROM;
         st.dbc   <= `PRSD_RST_DBC;
         st.sdram_config_register   <= `PRSD_RST_SDC;
      end else begin
         st <= next_st;
      end
   end

   assign prdata   = st.prdata;
   assign pready   = st.pready;
   assign pslverr  = st.pslverr;
   assign req_done = st.done;
   assign req_err  = st.err;
   assign mem      = st.mem;
endmodule

/* design/prsd_wait_ctr.sv */
// wait counter for rom strobe states: programmed waits or ready, whichever is longer
// assumes: load pulses at the address state, step each strobe state
`timescale 1ns/10ps
module prsd_wait_ctr (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       load,
   input  wire logic [2:0] waits,
   input  wire logic       step,
   input  wire logic       ready_n,
   // result
   output logic            done
);
   import prsd_pkg::*;

   typedef struct packed {
      logic [2:0] cnt;
   } prsd_wst_t;

   prsd_wst_t st, next_st;

   // count down; done only when count spent and ready active
   always_comb begin
      next_st = st;
      if (load) begin
         next_st.cnt = waits;
      end else if (step && st.cnt != 3'h0) begin
         next_st.cnt = st.cnt - 3'h1;
      end
   end

   assign done = step && (st.cnt == 3'h0) && !ready_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

/* dv/prsd_mem_model.sv */
// rom side of the memory bus: ready answers after a set count of strobe states
// assumes: fed from the sequencer's registered memory outputs
`timescale 1ns/10ps
module prsd_mem_model (
   // clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // sequencer pins and answer delay
   input wire prsd_pkg::prsd_mem_t mem,
   input wire logic [2:0]          slow,
   output logic                    ready_n
);
   import prsd_pkg::*;
   logic [2:0] cnt;

   // strobe states seen in the current access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
      end else if (mem.rom_addr_st || !mem.rom_strobe) begin
         cnt <= 3'h0;
      end else if (cnt != 3'h7) begin
         cnt <= cnt + 3'h1;
      end
   end
   // ready low once the delay is spent, pulled up outside strobe states
   assign ready_n = !(mem.rom_strobe && !mem.rom_addr_st && cnt >= slow);
endmodule

/* dv/prsd_seq_monitor.sv */
// checker on the sequencer ports: rom framing, sdram command spacing
// assumes: bound onto prsd_seq, one clock, reset active low
`timescale 1ns/10ps
module prsd_seq_monitor (
   // clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // core side
   input wire prsd_pkg::prsd_req_t req,
   input wire logic                req_done,
   // pins
   input wire logic                bus_width_strap_pin,
   input wire logic                ready_n,
   input wire prsd_pkg::prsd_mem_t mem
);
   import prsd_pkg::*;
   logic strobe_st;

   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // strobe state: strobe without the address pulse
   assign strobe_st = mem.rom_strobe && !mem.rom_addr_st;

   a_rom_block_only: assert property ($rose(mem.rom_cs) |-> req.valid && !req.sdram && req.block == 3'h7)
      else $error("rom cycle outside block seven");
   a_rom_no_write: assert property (mem.rom_addr_st |-> !(req.src inside {prsd_src_store, prsd_src_blkst}))
      else $error("rom cycle for a write source");
   a_rom_width: assert property (mem.rom_addr_st |-> mem.wide16 == bus_width_strap_pin)
      else $error("rom width differs from strap");
   a_addr_then_strobe: assert property (mem.rom_addr_st |=> strobe_st)
      else $error("address state not followed by strobe");
   a_strobe_repeat: assert property (strobe_st && ready_n |=> strobe_st)
      else $error("strobe ended without ready");
   a_pre_to_act: assert property (mem.sd_cmd == prsd_cmd_pre |-> ##[1:2] mem.sd_cmd == prsd_cmd_act)
      else $error("active missing after precharge");
   a_act_to_access: assert property (mem.sd_cmd == prsd_cmd_act
      |-> ##[1:2] mem.sd_cmd inside {prsd_cmd_rd, prsd_cmd_wr}) else $error("access missing after active");
   a_read_capture: assert property (mem.sd_cmd == prsd_cmd_rd |-> ##2 mem.sd_capture)
      else $error("no capture two clocks after read");
   a_capture_cause: assert property (mem.sd_capture |-> $past(mem.sd_cmd, 2) == prsd_cmd_rd)
      else $error("capture without read two clocks before");
   a_done_idle: assert property (req_done |=> mem.sd_cmd == prsd_cmd_nop && !mem.rom_addr_st)
      else $error("no idle state after cycle");

   // main scenarios reached
   c_rom_wide: cover property (mem.rom_addr_st && mem.wide16);
   c_sd_open: cover property (mem.sd_cmd == prsd_cmd_pre);
   c_sd_burst: cover property (mem.sd_capture ##1 mem.sd_capture);
endmodule

bind prsd_seq prsd_seq_monitor prsd_seq_monitor_inst (.pclk(pclk), .presetn(presetn), .req(req),
   .req_done(req_done), .bus_width_strap_pin(bus_width_strap_pin), .ready_n(ready_n), .mem(mem));

/* dv/test_prsd_seq.sv */
// self-checking bench: apb registers, page-rom and sdram request sequences
// assumes: package, design, monitor and memory model compiled before it
`timescale 1ns/10ps
module test_prsd_seq;
   import prsd_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   prsd_req_t   req;
   prsd_mem_t   mem;
   logic        req_done, req_err, bus_width_strap_pin, auto_refresh, ready_n;
   logic [2:0]  slow;
   logic [3:0]  c_pre = '0, c_act = '0, c_cmd = '0, c_cap = '0, c_beat = '0, c_off = '0;
   logic [32:0] exp_rd[$];
   logic [24:0] exp_rq[$];
   logic [11:0] open_row[4];
   logic [3:0]  row_ok;
   int          n_mismatch = 0, n_checks = 0;
   prsd_src_t   srcs[7] = '{prsd_src_load, prsd_src_fetch, prsd_src_store, prsd_src_icache,
                            prsd_src_dcache, prsd_src_blkld, prsd_src_blkst};
   prsd_src_t   rsrc[5] = '{prsd_src_load, prsd_src_fetch, prsd_src_dma, prsd_src_icache, prsd_src_blkld};
   logic [31:0] masks[5] = '{32'h1, 32'h7, 32'h17, 32'h1, 32'h3};

   prsd_seq prsd_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
      .req_done(req_done), .req_err(req_err), .bus_width_strap_pin(bus_width_strap_pin),
      .auto_refresh(auto_refresh), .ready_n(ready_n), .mem(mem));
   prsd_mem_model prsd_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem(mem), .slow(slow),
      .ready_n(ready_n));

   // ********************
   // helpers
   // ********************
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [24:0] ex(input logic e, input int p, c, k, b, o);
      return {e, 4'(p), 4'(p), 4'(c), 4'(k), 4'(b), 4'(o)};
   endfunction

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(33'h1, 33'h0, "apb hang");
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_rd.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // one core request, valid dropped on the completion pulse
   task automatic run_req(input prsd_src_t s, input logic sd, input logic [2:0] blk,
                          input logic [1:0] bk, input logic [11:0] rw, input logic [24:0] e);
      int n;
      exp_rq.push_back(e);
      req <= '{valid: 1'b1, src: s, sdram: sd, block: blk, bank: bk, row: rw, col: 8'($urandom),
               size: 2'($urandom % 3)};
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(req_done || req_err) && n < 200);
      req.valid <= 1'b0;
      if (n >= 200) chk(33'h1, 33'h0, "request hang");
      @(posedge pclk);
   endtask

   // sdram request with on/off page worked out from a row table
   task automatic sd_req(input prsd_src_t s, input logic [1:0] bk, input logic [11:0] rw);
      logic off, w;
      int n;
      off = !row_ok[bk] || open_row[bk] != rw;
      w = s inside {prsd_src_store, prsd_src_blkst};
      n = (s inside {prsd_src_load, prsd_src_fetch, prsd_src_store}) ? 1 : 4;
      run_req(s, 1'b1, 3'h0, bk, rw, ex(1'b0, off, n, w ? 0 : n, 0, 0));
      row_ok[bk] = 1'b1;
      open_row[bk] = rw;
   endtask

   // result watcher: counts memory activity, compares at each completion
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         chk({pslverr, prdata}, exp_rd.pop_front(), "apb read");
      end
      c_pre += 4'(mem.sd_cmd == prsd_cmd_pre);
      c_act += 4'(mem.sd_cmd == prsd_cmd_act);
      c_cmd += 4'(mem.sd_cmd inside {prsd_cmd_rd, prsd_cmd_wr});
      c_cap += 4'(mem.sd_capture);
      c_beat += 4'(mem.rom_addr_st);
      c_off += 4'(mem.rom_addr_st && mem.off_page);
      if (req_done || req_err) begin
         chk(33'({req_err, c_pre, c_act, c_cmd, c_cap, c_beat, c_off}), 33'(exp_rq.pop_front()), "request");
         {c_pre, c_act, c_cmd, c_cap, c_beat, c_off} = '0;
      end
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ********************
   // tests
   // ********************
   initial begin
      v = $urandom(31);
      {psel, penable, pwrite, paddr, pwdata, auto_refresh, bus_width_strap_pin, slow} = '0;
      req = '0;
      row_ok = '0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(12'(i * 4), 33'h0);
      rd(12'h020, {1'b1, 32'h0});
      foreach (masks[i]) begin
         v = $urandom & masks[i];
         wr(12'(i * 4), v);
         rd(12'(i * 4), {1'b0, v});
      end
      $display("registers finished");
      wr(12'h000, 32'h0);
      wr(12'h004, 32'($urandom % 8));
      run_req(prsd_src_load, 1'b0, 3'h7, 2'h0, 12'h0, ex(1'b1, 0, 0, 0, 0, 0));
      wr(12'h000, 32'h1);
      run_req(prsd_src_load, 1'b0, 3'h3, 2'h0, 12'h0, ex(1'b1, 0, 0, 0, 0, 0));
      run_req(prsd_src_store, 1'b0, 3'h7, 2'h0, 12'h0, ex(1'b1, 0, 0, 0, 0, 0));
      run_req(prsd_src_blkst, 1'b0, 3'h7, 2'h0, 12'h0, ex(1'b1, 0, 0, 0, 0, 0));
      run_req(prsd_src_dcache, 1'b0, 3'h7, 2'h0, 12'h0, ex(1'b1, 0, 0, 0, 0, 0));
      for (int k = 0; k < 3; k++) begin
         bus_width_strap_pin <= (k > 0);
         wr(12'h008, {27'h0, k == 2, 1'b0, 3'($urandom)});
         foreach (rsrc[i]) begin
            slow <= 3'($urandom % 4);
            run_req(rsrc[i], 1'b0, 3'h7, 2'h0, 12'h0,
                    ex(1'b0, 0, 0, 0, i > 2 ? (k > 0 ? 8 : 4) : 1, (i > 2 && k == 2) ? 2 : 1));
         end
      end
      $display("page rom finished");
      wr(12'h00c, 32'($urandom % 2));
      for (int p = 0; p < 3; p++) begin
         wr(12'h010, 32'($urandom % 4));
         if (p == 2) begin
            auto_refresh <= 1'b1;
            @(posedge pclk);
            auto_refresh <= 1'b0;
            row_ok = '0;
         end
         foreach (srcs[i]) sd_req(srcs[i], 2'($urandom % 2), p == 1 ? 12'h5 : 12'($urandom % 2));
      end
      $display("sdram finished");
      give_verdict();
   end

   // watchdog against a hung handshake
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
endmodule
